// file: core/tpwm_chan.sv
`timescale 1ns/1ps
module tpwm_chan #(
  parameter int unsigned WIDTH = 16 // Counter width.
) (
  input wire logic ref_clk, // Block clock.
  input wire logic nrst, // Synchronous reset, active low.
  input wire tpwm_pkg::tpwm_cfg_t cfg, // Mode, width select and reload value.
  input wire logic tick, // Count clock enable, one cycle.
  input wire logic trig, // Start trigger, one cycle.
  input wire logic stop, // Software stop, one cycle.
  output logic [WIDTH-1:0] count, // Present count.
  output logic running, // Channel is counting.
  output logic irq, // Channel interrupt, one cycle.
  output logic illegal // Mode code is prohibited.
);

  if (WIDTH != tpwm_pkg::CNT_W) begin : g_bad_width
    $error("tpwm_chan: WIDTH must equal the package counter width");
  end

  tpwm_pkg::tpwm_chan_st_t s_q, s_d;
  logic [2:0] op;
  logic low, legal, is_int, is_cap, is_evt, is_one, is_c1, down, retrig_ok;
  logic [WIDTH-1:0] msk, val, dec;

  always_comb begin
    op = cfg.mode[3:1];
    low = cfg.mode[0];
    is_int = (op == tpwm_pkg::OP_INTERVAL);
    is_cap = (op == tpwm_pkg::OP_CAPTURE);
    is_evt = (op == tpwm_pkg::OP_EVENT);
    is_one = (op == tpwm_pkg::OP_ONECOUNT);
    is_c1 = (op == tpwm_pkg::OP_CAPONE);
    legal = is_int | is_cap | (is_evt & !low) | is_one | (is_c1 & !low);
    down = is_int | is_evt | is_one;
    msk = cfg.split ? WIDTH'(16'h00ff) : '1;
    val = cfg.reload & msk;
    dec = (s_q.cnt - 1'b1) & msk;
    // A running capture channel restarts on every trigger; one-count only when allowed.
    retrig_ok = (is_one & low) | is_cap;
    s_d = s_q;
    s_d.irq = 1'b0;
    if (stop || !legal) begin
      s_d.run = 1'b0;
    end else if (trig && (!s_q.run || retrig_ok)) begin
      s_d.run = 1'b1;
      s_d.irq = s_q.run ? 1'b1 : (low & (is_int | is_cap));
      if (!down) begin
        s_d.cnt = '0;
      end else if (is_one && val == '0) begin
        s_d.run = 1'b0;
        s_d.irq = 1'b1;
      end else begin
        s_d.cnt = val;
      end
    end else if (s_q.run && tick) begin
      if (!down) begin
        s_d.cnt = (s_q.cnt + 1'b1) & msk;
      end else if (is_one) begin
        s_d.cnt = dec;
        if (dec == '0) begin
          s_d.run = 1'b0;
          s_d.irq = 1'b1;
        end
      end else if ((s_q.cnt & msk) == '0) begin
        s_d.cnt = val;
        s_d.irq = 1'b1;
      end else begin
        s_d.cnt = dec;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.cnt;
  assign running = s_q.run;
  assign irq = s_q.irq;
  assign illegal = !legal;

  sequence oc_busy_trig;
    legal && !stop && s_q.run && trig;
  endsequence

  a_oc_ignore_trig: assert property (@(posedge ref_clk) disable iff (!nrst)
    oc_busy_trig and (is_one && !low && !tick) |=> !irq && running)
    else $error("one-count channel reacted to a trigger while counting");
  a_oc_retrig_irq: assert property (@(posedge ref_clk) disable iff (!nrst)
    oc_busy_trig and (is_one && low && val != '0) |=> irq && running && count == $past(val))
    else $error("one-count retrigger did not restart with an interrupt");
  a_start_irq_sel: assert property (@(posedge ref_clk) disable iff (!nrst)
    legal && !stop && !s_q.run && trig && (is_int || is_cap) |=> running && irq == $past(low))
    else $error("start interrupt does not follow the mode low bit");
  a_event_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
    legal && !stop && !s_q.run && trig && is_evt && val != '0 |=> !irq)
    else $error("event counter interrupted at count start");
  a_reload_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    legal && !stop && !trig && s_q.run && tick && is_int && (s_q.cnt & msk) == '0
    |=> irq && count == $past(val))
    else $error("interval channel failed to reload at zero");

endmodule : tpwm_chan

// file: core/tpwm_pkg.sv
package tpwm_pkg;

  localparam int unsigned CNT_W = 16;

  // Register byte addresses on the bus.
  localparam logic [7:0] ADR_PERIOD = 8'h00;
  localparam logic [7:0] ADR_COMPARE = 8'h04;
  localparam logic [7:0] ADR_MMODE = 8'h08;
  localparam logic [7:0] ADR_SMODE = 8'h0c;
  localparam logic [7:0] ADR_CTRL = 8'h10;
  localparam logic [7:0] ADR_STAT = 8'h14;
  localparam logic [7:0] ADR_MASK = 8'h18;
  localparam logic [7:0] ADR_COUNT = 8'h1c;

  // Slave mode register fields.
  localparam int unsigned SM_CKS = 15;
  localparam int unsigned SM_CCS = 12;
  localparam int unsigned SM_SPLIT = 11;
  localparam int unsigned SM_STS_LO = 8;
  localparam int unsigned SM_MD_LO = 0;

  // Control register fields.
  localparam int unsigned CT_START_M = 0;
  localparam int unsigned CT_START_S = 1;
  localparam int unsigned CT_STOP_M = 2;
  localparam int unsigned CT_STOP_S = 3;
  localparam int unsigned CT_PSA_LO = 4;
  localparam int unsigned CT_PSB_LO = 8;
  localparam int unsigned CT_TOM = 12;

  // Status and mask bits.
  localparam int unsigned ST_MIRQ = 0;
  localparam int unsigned ST_SIRQ = 1;
  localparam int unsigned ST_ERR = 2;

  localparam logic [15:0] PERIOD_RST = 16'h0000;
  localparam logic [15:0] COMPARE_RST = 16'h0000;
  localparam logic [3:0] MMODE_RST = 4'h0;
  localparam logic [15:0] SMODE_RST = 16'h0000;
  localparam logic [3:0] PS_RST = 4'h0;
  localparam logic [2:0] MASK_RST = 3'h0;

  typedef enum logic [2:0] {
    OP_INTERVAL = 3'b000,
    OP_CAPTURE = 3'b010,
    OP_EVENT = 3'b011,
    OP_ONECOUNT = 3'b100,
    OP_CAPONE = 3'b110
  } tpwm_op_t;

  typedef enum logic [2:0] {
    TRG_SOFT = 3'b000,
    TRG_EDGE = 3'b001,
    TRG_BOTH = 3'b010,
    TRG_MASTER = 3'b100
  } tpwm_trig_t;

  typedef struct packed {
    logic [3:0] mode;
    logic split;
    logic [CNT_W-1:0] reload;
  } tpwm_cfg_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic run;
    logic irq;
  } tpwm_chan_st_t;

  typedef struct packed {
    logic [15:0] period;
    logic [15:0] compare;
    logic [3:0] mmode;
    logic [15:0] smode;
    logic [3:0] psa;
    logic [3:0] psb;
    logic tom;
    logic [2:0] stat;
    logic [2:0] mask;
    logic start_m;
    logic start_s;
    logic stop_m;
    logic stop_s;
    logic [15:0] div;
    logic tick_a;
    logic tick_b;
    logic pin;
    logic ack;
    logic [31:0] rdat;
    logic irq;
    logic tout;
    logic mirq_dly;
  } tpwm_top_st_t;

endpackage : tpwm_pkg

// file: core/tpwm_top.sv
// Behaviour
// - Interval or capture: low mode bit 1 interrupts and changes output at start.
// - Event counter: low bit must be 0, no interrupt at count start.
// - One-count, low bit 0: triggers during counting ignored, no interrupt.
// - One-count, low bit 1: trigger during counting restarts and interrupts.
// - Capture one-count: low bit 0, no start interrupt, triggers ignored while counting.
// - Master period is period value plus one count clock cycles, 16 bits.
// - Slave mode bit 7 of upper byte picks prescaler clock a or b.
// - Slave mode bit 4 of upper byte picks operation clock or pin edges.
// - Slave mode bit 3 of upper byte picks 16-bit or 8-bit counting.
// - Slave trigger field: software, pin edge, both edges, master interrupt.
// - Mode field decodes interval, capture, event, one-count, capture one-count.
// - PWM: master interval timer, slave one-count retriggered by master interrupt.
// - Duty equals compare value over period value plus one, in percent.
// - Slave output mode: output set by master, cleared by slave interrupt.
`timescale 1ns/1ps
module tpwm_top (
  input wire logic ref_clk, // 40 MHz block clock.
  input wire logic nrst, // Synchronous reset, active low.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte lanes.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire logic slave_timer_input_pin, // Channel 1 timer input.
  output logic irq, // Level interrupt.
  output logic timer_out // Channel 1 pulse output.
);

  tpwm_pkg::tpwm_top_st_t s_q, s_d;
  tpwm_pkg::tpwm_cfg_t m_cfg, s_cfg;
  logic [15:0] m_cnt, s_cnt, mask_a, mask_b;
  logic m_run, s_run, m_irq, s_irq, m_bad, s_bad, sts_bad;
  logic m_tick, s_tick, s_trig, pin_rise, pin_both, req, wr;
  logic [2:0] set, clr;
  logic [31:0] wv;

  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : lanes

  always_comb begin
    m_cfg.mode = s_q.mmode;
    m_cfg.split = 1'b0;
    m_cfg.reload = s_q.period;
    s_cfg.mode = s_q.smode[tpwm_pkg::SM_MD_LO +: 4];
    s_cfg.split = s_q.smode[tpwm_pkg::SM_SPLIT];
    s_cfg.reload = s_q.compare;
  end

  always_comb begin
    pin_rise = slave_timer_input_pin & !s_q.pin;
    pin_both = slave_timer_input_pin ^ s_q.pin;
    m_tick = s_q.tick_a;
    if (s_q.smode[tpwm_pkg::SM_CCS]) begin
      s_tick = pin_rise;
    end else begin
      s_tick = s_q.smode[tpwm_pkg::SM_CKS] ? s_q.tick_b : s_q.tick_a;
    end
    sts_bad = 1'b0;
    unique case (s_q.smode[tpwm_pkg::SM_STS_LO +: 3])
      tpwm_pkg::TRG_SOFT: s_trig = s_q.start_s;
      tpwm_pkg::TRG_EDGE: s_trig = s_q.start_s | pin_rise;
      tpwm_pkg::TRG_BOTH: s_trig = s_q.start_s | pin_both;
      tpwm_pkg::TRG_MASTER: s_trig = s_q.start_s | m_irq;
      default: begin
        s_trig = 1'b0;
        sts_bad = 1'b1;
      end
    endcase
  end

  tpwm_chan #(
    .WIDTH(tpwm_pkg::CNT_W)
  ) u_master (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .cfg(m_cfg),
    .tick(m_tick),
    .trig(s_q.start_m),
    .stop(s_q.stop_m),
    .count(m_cnt),
    .running(m_run),
    .irq(m_irq),
    .illegal(m_bad)
  );

  tpwm_chan #(
    .WIDTH(tpwm_pkg::CNT_W)
  ) u_slave (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .cfg(s_cfg),
    .tick(s_tick),
    .trig(s_trig),
    .stop(s_q.stop_s),
    .count(s_cnt),
    .running(s_run),
    .irq(s_irq),
    .illegal(s_bad)
  );

  always_comb begin
    req = wb_cyc_i & wb_stb_i & !s_q.ack;
    wr = req & wb_we_i;
    wv = '0;
    clr = '0;
    s_d = s_q;
    s_d.start_m = 1'b0;
    s_d.start_s = 1'b0;
    s_d.stop_m = 1'b0;
    s_d.stop_s = 1'b0;
    s_d.ack = req;
    s_d.pin = slave_timer_input_pin;

    // Free-running divider; each prescaler tick is one cycle wide.
    mask_a = (16'h0001 << s_q.psa) - 16'h0001;
    mask_b = (16'h0001 << s_q.psb) - 16'h0001;
    s_d.div = s_q.div + 16'h0001;
    s_d.tick_a = (s_q.div & mask_a) == mask_a;
    s_d.tick_b = (s_q.div & mask_b) == mask_b;

    if (wr) begin
      unique case (wb_adr_i)
        tpwm_pkg::ADR_PERIOD: begin
          wv = lanes({16'h0000, s_q.period}, wb_dat_i, wb_sel_i);
          s_d.period = wv[15:0];
        end
        tpwm_pkg::ADR_COMPARE: begin
          wv = lanes({16'h0000, s_q.compare}, wb_dat_i, wb_sel_i);
          s_d.compare = wv[15:0];
        end
        tpwm_pkg::ADR_MMODE: begin
          wv = lanes({28'h0000000, s_q.mmode}, wb_dat_i, wb_sel_i);
          s_d.mmode = wv[3:0];
        end
        tpwm_pkg::ADR_SMODE: begin
          wv = lanes({16'h0000, s_q.smode}, wb_dat_i, wb_sel_i);
          s_d.smode = wv[15:0];
        end
        tpwm_pkg::ADR_CTRL: begin
          wv = lanes({19'h0, s_q.tom, s_q.psb, s_q.psa, 4'h0}, wb_dat_i, wb_sel_i);
          s_d.start_m = wv[tpwm_pkg::CT_START_M];
          s_d.start_s = wv[tpwm_pkg::CT_START_S];
          s_d.stop_m = wv[tpwm_pkg::CT_STOP_M];
          s_d.stop_s = wv[tpwm_pkg::CT_STOP_S];
          s_d.psa = wv[tpwm_pkg::CT_PSA_LO +: 4];
          s_d.psb = wv[tpwm_pkg::CT_PSB_LO +: 4];
          s_d.tom = wv[tpwm_pkg::CT_TOM];
        end
        tpwm_pkg::ADR_STAT: begin
          wv = lanes(32'h00000000, wb_dat_i, wb_sel_i);
          clr = wv[2:0];
        end
        tpwm_pkg::ADR_MASK: begin
          wv = lanes({29'h0, s_q.mask}, wb_dat_i, wb_sel_i);
          s_d.mask = wv[2:0];
        end
        default: wv = '0;
      endcase
    end

    // A new event wins over a write-one clear in the same cycle.
    set = '0;
    set[tpwm_pkg::ST_MIRQ] = m_irq;
    set[tpwm_pkg::ST_SIRQ] = s_irq;
    set[tpwm_pkg::ST_ERR] = m_bad | s_bad | sts_bad;
    s_d.stat = (s_q.stat & ~clr) | set;
    s_d.irq = |(s_d.stat & s_d.mask);

    // The slave reloads one cycle after the master interrupt, so the set uses a delayed
    // copy; the high time is then exactly the compare count. Set wins when both arrive,
    // which keeps the output high through a retrigger.
    s_d.mirq_dly = m_irq;
    if (s_q.tom) begin
      if (s_q.mirq_dly) begin
        s_d.tout = 1'b1;
      end else if (s_irq) begin
        s_d.tout = 1'b0;
      end
    end else if (s_irq) begin
      s_d.tout = !s_q.tout;
    end

    s_d.rdat = '0;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        tpwm_pkg::ADR_PERIOD: s_d.rdat = {16'h0000, s_q.period};
        tpwm_pkg::ADR_COMPARE: s_d.rdat = {16'h0000, s_q.compare};
        tpwm_pkg::ADR_MMODE: s_d.rdat = {28'h0000000, s_q.mmode};
        tpwm_pkg::ADR_SMODE: s_d.rdat = {16'h0000, s_q.smode};
        tpwm_pkg::ADR_CTRL: s_d.rdat = {19'h0, s_q.tom, s_q.psb, s_q.psa, 2'b00, s_run, m_run};
        tpwm_pkg::ADR_STAT: s_d.rdat = {29'h0, s_q.stat};
        tpwm_pkg::ADR_MASK: s_d.rdat = {29'h0, s_q.mask};
        tpwm_pkg::ADR_COUNT: s_d.rdat = {s_cnt, m_cnt};
        default: s_d.rdat = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.period <= tpwm_pkg::PERIOD_RST;
      s_q.compare <= tpwm_pkg::COMPARE_RST;
      s_q.mmode <= tpwm_pkg::MMODE_RST;
      s_q.smode <= tpwm_pkg::SMODE_RST;
      s_q.psa <= tpwm_pkg::PS_RST;
      s_q.psb <= tpwm_pkg::PS_RST;
      s_q.mask <= tpwm_pkg::MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o = s_q.rdat;
  assign wb_ack_o = s_q.ack;
  assign irq = s_q.irq;
  assign timer_out = s_q.tout;

  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  a_wb_ack_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
    bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge is not a single cycle after the request");
  a_tout_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_q.tom && s_q.mirq_dly |=> timer_out)
    else $error("master interrupt did not set the slave output");
  a_tout_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_q.tom && s_irq && !s_q.mirq_dly |=> !timer_out)
    else $error("slave interrupt did not clear the slave output");
  a_irq_level: assert property (@(posedge ref_clk) disable iff (!nrst)
    (s_q.stat & s_q.mask) != 3'h0 && !wr |=> irq)
    else $error("unmasked status bit did not raise the interrupt");
  a_master_trig: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_q.smode[10:8] == tpwm_pkg::TRG_MASTER && m_irq && !s_bad && !s_q.stop_s
    && !s_q.smode[tpwm_pkg::SM_SPLIT] && s_q.compare != 16'h0000 |=> s_run)
    else $error("master interrupt did not trigger the slave");

endmodule : tpwm_top

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic pin = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] q;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq;
  logic timer_out;
  int bad_count = 0;
  int compares = 0;
  int seed = 32'h2702b661;
  int hi, per, n, p, c, tmo, i;
  logic [15:0] sm [0:13];
  logic exp_bit [0:13];

  tpwm_top u_tpwm_top (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .slave_timer_input_pin(pin),
    .irq(irq),
    .timer_out(timer_out)
  );

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Classic single cycle; the answer is awaited, never assumed.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 50) begin
      bad_count++;
      report_and_stop();
    end
  endtask : wb

  task automatic wt(input logic v, input int lim, output int k);
    k = 0;
    while (timer_out !== v && k < lim) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= lim) tmo = 1;
  endtask : wt

  // One full high and low phase of the output, sampled on clock edges.
  task automatic meas;
    tmo = 0;
    wt(1'b0, 4000, n);
    wt(1'b1, 4000, n);
    wt(1'b0, 4000, hi);
    wt(1'b1, 4000, n);
    per = hi + n;
    if (tmo != 0) begin
      bad_count++;
      report_and_stop();
    end
  endtask : meas

  task automatic setup(input int pv, input int cv, input logic [15:0] s, input logic [31:0] ct);
    wb(1'b1, tpwm_pkg::ADR_CTRL, 32'h0000000c);
    wb(1'b1, tpwm_pkg::ADR_STAT, 32'h00000007);
    wb(1'b1, tpwm_pkg::ADR_PERIOD, pv);
    wb(1'b1, tpwm_pkg::ADR_COMPARE, cv);
    wb(1'b1, tpwm_pkg::ADR_MMODE, 32'h0);
    wb(1'b1, tpwm_pkg::ADR_SMODE, {16'h0, s});
    wb(1'b1, tpwm_pkg::ADR_CTRL, ct);
  endtask : setup

  initial begin
    sm = '{16'h0001, 16'h0000, 16'h0006, 16'h000c, 16'h0005, 16'h0004, 16'h0008,
           16'h0009, 16'h0007, 16'h0002, 16'h000d, 16'h0308, 16'h0708, 16'h0508};
    exp_bit = '{1, 0, 0, 0, 1, 0, 0, 0, 1, 1, 1, 1, 1, 1};
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    for (i = 0; i < 9; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0);
      chk(q, 32'h0);
    end
    wb(1'b1, tpwm_pkg::ADR_PERIOD, 32'hffffffff);
    wb(1'b0, tpwm_pkg::ADR_PERIOD, 32'h0);
    chk(q, 32'h0000ffff);
    wb(1'b1, tpwm_pkg::ADR_SMODE, 32'hffffffff);
    wb(1'b0, tpwm_pkg::ADR_SMODE, 32'h0);
    chk(q, 32'h0000ffff);
    wb(1'b1, 8'h20, 32'hffffffff);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    $display("test registers done");
    // Pulse period and duty, random plus the widest duty.
    for (i = 0; i < 5; i++) begin
      p = 8 + ($random(seed) & 32'h1f);
      c = (i == 4) ? p : 1 + ($random(seed) & 32'h7);
      setup(p, c, 16'h0409, 32'h00001003);
      meas();
      chk(per, p + 1);
      chk(hi, c);
    end
    $display("test pwm done");
    wb(1'b0, tpwm_pkg::ADR_STAT, 32'h0);
    chk(q & 32'h3, 32'h3);
    wb(1'b1, tpwm_pkg::ADR_MASK, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b0);
    wb(1'b1, tpwm_pkg::ADR_MASK, 32'h2);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b1);
    wb(1'b1, tpwm_pkg::ADR_CTRL, 32'h0000000c);
    wb(1'b1, tpwm_pkg::ADR_STAT, 32'h7);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b0);
    wb(1'b1, tpwm_pkg::ADR_MASK, 32'h0);
    $display("test interrupt done");
    // Start interrupt per mode, then prohibited codes raise the error bit.
    for (i = 0; i < 14; i++) begin
      setup(100, 100, sm[i], 32'h00000002);
      repeat (8) @(posedge ref_clk);
      wb(1'b0, tpwm_pkg::ADR_STAT, 32'h0);
      if (i < 6) chk(q[1], exp_bit[i]);
      else chk(q[2], exp_bit[i]);
    end
    $display("test modes done");
    setup(9, 25, 16'h0409, 32'h00001003);
    repeat (30) @(posedge ref_clk);
    wt(1'b0, 80, n);
    chk(n, 80);
    setup(9, 25, 16'h0408, 32'h00001003);
    meas();
    chk(hi, 25);
    chk(per, 30);
    $display("test retrigger done");
    setup(4000, 16'h0105, 16'h0c09, 32'h00001003);
    wt(1'b0, 100, n);
    wt(1'b1, 9000, n);
    wt(1'b0, 100, hi);
    chk(hi, 5);
    setup(19, 4, 16'h8409, 32'h00001103);
    meas();
    chk(hi >= 7 && hi <= 9, 1'b1);
    setup(9, 3, 16'h1408, 32'h00001003);
    repeat (30) @(posedge ref_clk);
    wt(1'b0, 60, n);
    chk(n, 60);
    wb(1'b0, tpwm_pkg::ADR_STAT, 32'h0);
    chk(q[1], 1'b0);
    for (i = 0; i < 3; i++) begin
      pin <= 1'b1;
      repeat (2) @(posedge ref_clk);
      pin <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
    wb(1'b0, tpwm_pkg::ADR_STAT, 32'h0);
    chk(q[1], 1'b1);
    $display("test clocks done");
    report_and_stop();
  end
endmodule : tb_top
